// ### hw/fepc_codec.sv
// 100 Mbps coding path: mii nibbles to nrzi line bits and back, with apb mode registers
// assumes the mac runs on pclk and line clocks arrive asynchronously, far slower than pclk
//
// Decided for this implementation: the APB register port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "fepc_regs.svh"

// Operation
// - mac offers one nibble per transmit slot; device takes one per slot
// - each taken nibble leaves as a serial stream timed by clocks
// - frames open with J K and close with T R code-groups
// - receiver finds J K to open a frame and T to close it, then skips one group
// - collision is raised while receiving during transmission
// - transmit and receive activity drive carrier sense and collision toward the mac
// - coding bypass by mode bit 1 or by the bypass strap
// - after reset the scrambler is seeded with the phy address, or with 1 for address zero
// - key stream bit is x[n-11] xor x[n-9], period 2047
// - scrambling adds the key bit modulo 2 to each plain bit
// - descrambler adds a local key stream of the same recursion
// - copper mode scrambles every code-group unless disabled
// - mode bit 2 turns scrambling off, groups pass straight out
// - fiber mode skips scrambling both ways but keeps the coding
// - line output is nrzi encoded
// - receive: nrzi to nrz, descramble, deserialize, decode to nibbles
// - symbol mode passes five bit symbols without coding or scrambling
// - idle, start, end and error symbols use their fixed code-groups
// - transmit error inside a frame sends the error symbol
module fepc_codec
  import fepc_pkg::*;
(
  // clock and reset
  input  wire  logic                     pclk,
  input  wire  logic                     presetn,
  // apb slave
  input  wire  logic [`FEPC_ADDR_W-1:0]  paddr,
  input  wire  logic                     psel,
  input  wire  logic                     penable,
  input  wire  logic                     pwrite,
  input  wire  logic [31:0]              pwdata,
  output logic [31:0]                    prdata,
  output logic                           pready,
  output logic                           pslverr,
  // mii transmit
  input  wire  logic [3:0]               mii_txd,
  input  wire  logic                     mii_tx_en,
  input  wire  logic                     mii_tx_er,
  output logic                           mii_tx_take,
  // mii receive and status
  output logic [3:0]                     mii_rxd,
  output logic                           mii_rx_dv,
  output logic                           mii_rx_er,
  output logic                           mii_rx_strobe,
  output logic                           mii_crs,
  output logic                           mii_col,
  // straps
  input  wire  logic [4:0]               phy_addr,
  input  wire  logic                     coding_bypass_strap,
  // line
  input  wire  logic                     tx_line_clk,
  output logic                           tx_line_data,
  input  wire  logic                     rx_line_clk,
  input  wire  logic                     rx_line_data
);

  logic [2:0]     mode;
  logic [4:0]     addr_s1, addr_s2;
  logic           strap_s1, strap_s2;
  logic [2:0]     txc_s, rxc_s;
  logic [1:0]     rxd_s;
  logic [2:0]     seed_stage;
  logic           seed_load;
  logic           tx_rise, rx_rise, tx_last, rx_last;
  logic           bypass, scr_on, descr_on;
  fepc_tx_state_t tx_state, next_tx_state;
  fepc_rx_state_t rx_state;
  logic [2:0]     tx_bit, rx_bit;
  logic [4:0]     tx_shift, next_group;
  logic           send_bit, tx_key, rx_key;
  logic           rx_prev, rx_nrz, rx_plain;
  logic [9:0]     rx_win;
  logic [4:0]     rx_grp;
  logic [4:0]     lock_cnt;
  logic           locked;
  logic           tx_busy, rx_busy;
  logic [10:0]    seed_val;
  logic [4:0]     dec_res;

  // 4b/5b data table
  function automatic logic [4:0] enc4b5b(input logic [3:0] n);
    case (n)
      4'h0: enc4b5b = 5'h1E;
      4'h1: enc4b5b = 5'h09;
      4'h2: enc4b5b = 5'h14;
      4'h3: enc4b5b = 5'h15;
      4'h4: enc4b5b = 5'h0A;
      4'h5: enc4b5b = 5'h0B;
      4'h6: enc4b5b = 5'h0E;
      4'h7: enc4b5b = 5'h0F;
      4'h8: enc4b5b = 5'h12;
      4'h9: enc4b5b = 5'h13;
      4'hA: enc4b5b = 5'h16;
      4'hB: enc4b5b = 5'h17;
      4'hC: enc4b5b = 5'h1A;
      4'hD: enc4b5b = 5'h1B;
      4'hE: enc4b5b = 5'h1C;
      default: enc4b5b = 5'h1D;
    endcase
  endfunction : enc4b5b

  // reverse table search, bit 4 of the result marks a valid data group
  function automatic logic [4:0] dec5b4b(input logic [4:0] g);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 0; i < 16; i++) begin
      if (enc4b5b(4'(i)) == g) r = {1'b1, 4'(i)};
    end
    dec5b4b = r;
  endfunction : dec5b4b

  // two-flop synchronisers for straps and line pins, plus edge history
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_s1  <= 5'h00;
      addr_s2  <= 5'h00;
      strap_s1 <= 1'b0;
      strap_s2 <= 1'b0;
      txc_s    <= 3'h0;
      rxc_s    <= 3'h0;
      rxd_s    <= 2'h0;
    end else begin
      addr_s1  <= phy_addr;
      addr_s2  <= addr_s1;
      strap_s1 <= coding_bypass_strap;
      strap_s2 <= strap_s1;
      txc_s    <= {txc_s[1:0], tx_line_clk};
      rxc_s    <= {rxc_s[1:0], rx_line_clk};
      rxd_s    <= {rxd_s[0], rx_line_data};
    end
  end

  assign tx_rise  = txc_s[1] & ~txc_s[2];
  assign rx_rise  = rxc_s[1] & ~rxc_s[2];
  assign bypass   = mode[`FEPC_MODE_BYPASS] | strap_s2;
  assign scr_on   = ~mode[`FEPC_MODE_FIBER] & ~mode[`FEPC_MODE_SCROFF] & ~bypass;
  assign descr_on = scr_on;
  assign tx_busy  = tx_state != FEPC_TX_IDLE;
  assign rx_busy  = rx_state != FEPC_RX_HUNT;

  // seed load once the address has passed both synchroniser flops, at the third edge after release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seed_stage <= 3'b000;
    end else begin
      seed_stage <= {seed_stage[1:0], 1'b1};
    end
  end
  assign seed_load = seed_stage == 3'b011;
  assign seed_val  = (addr_s2 == 5'h00) ? `FEPC_SEED_ZERO : {6'h00, addr_s2};

  // transmit and receive key stream generators
  fepc_lfsr #(.WIDTH(11)) u_tx_key (
    .pclk      (pclk),
    .presetn   (presetn),
    .load      (seed_load),
    .seed      (seed_val),
    .advance   (tx_rise),
    .train     (1'b0),
    .train_bit (1'b0),
    .pred      (tx_key)
  );
  fepc_lfsr #(.WIDTH(11)) u_rx_key (
    .pclk      (pclk),
    .presetn   (presetn),
    .load      (1'b0),
    .seed      (seed_val),
    .advance   (rx_rise),
    .train     (~locked),
    .train_bit (~rx_nrz),
    .pred      (rx_key)
  );

  // apb mode register write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode <= `FEPC_MODE_RESET;
    end else if (psel && penable && pwrite && paddr == `FEPC_MODE_OFS) begin
      mode <= pwdata[2:0];
    end
  end

  // apb read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= 32'h0000_0000;
      if (paddr == `FEPC_MODE_OFS) begin
        prdata[2:0] <= mode;
      end else if (paddr == `FEPC_STAT_OFS) begin
        prdata[`FEPC_STAT_TXBUSY]            <= tx_busy;
        prdata[`FEPC_STAT_RXBUSY]            <= rx_busy;
        prdata[`FEPC_STAT_LOCK]              <= locked;
        prdata[`FEPC_STAT_BYP]               <= bypass;
        prdata[`FEPC_STAT_ADDR+4:`FEPC_STAT_ADDR] <= addr_s2;
      end
    end
  end
  assign pready  = 1'b1;
  assign pslverr = psel && penable && paddr != `FEPC_MODE_OFS && paddr != `FEPC_STAT_OFS;

  // next code-group and framing step, taken at each group boundary
  assign tx_last     = tx_bit == `FEPC_BIT_LAST;
  assign mii_tx_take = tx_rise && tx_last;
  always_comb begin
    next_group    = `FEPC_CG_IDLE;
    next_tx_state = tx_state;
    if (bypass) begin
      next_group    = {mii_tx_er, mii_txd};
      next_tx_state = FEPC_TX_IDLE;
    end else begin
      case (tx_state)
        FEPC_TX_IDLE: begin
          if (mii_tx_en) begin
            next_group    = `FEPC_CG_J;
            next_tx_state = FEPC_TX_K;
          end
        end
        FEPC_TX_K: begin
          next_group    = `FEPC_CG_K;
          next_tx_state = FEPC_TX_DATA;
        end
        FEPC_TX_DATA: begin
          if (!mii_tx_en) begin
            next_group    = `FEPC_CG_T;
            next_tx_state = FEPC_TX_R;
          end else if (mii_tx_er) begin
            next_group = `FEPC_CG_H;
          end else begin
            next_group = enc4b5b(mii_txd);
          end
        end
        FEPC_TX_R: begin
          next_group    = `FEPC_CG_R;
          next_tx_state = FEPC_TX_IDLE;
        end
        default: next_tx_state = FEPC_TX_IDLE;
      endcase
    end
  end

  // serializer: msb first, one bit per line clock rise
  assign send_bit = tx_last ? next_group[4] : tx_shift[3];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_state     <= FEPC_TX_IDLE;
      tx_bit       <= `FEPC_BIT_LAST;
      tx_shift     <= `FEPC_CG_IDLE;
      tx_line_data <= 1'b0;
    end else if (tx_rise) begin
      tx_bit       <= tx_last ? `FEPC_BIT_FIRST : tx_bit + 3'h1;
      tx_shift     <= tx_last ? next_group : {tx_shift[3:0], 1'b0};
      tx_state     <= tx_last ? next_tx_state : tx_state;
      tx_line_data <= tx_line_data ^ (send_bit ^ (scr_on & tx_key));
    end
  end

  // nrzi to nrz, then descramble bit by bit
  assign rx_nrz   = rxd_s[1] ^ rx_prev;
  assign rx_plain = rx_nrz ^ (descr_on & rx_key);
  assign rx_last  = rx_bit == `FEPC_BIT_LAST;
  assign rx_grp   = {rx_win[3:0], rx_plain};
  assign dec_res  = dec5b4b(rx_grp);

  // descrambler lock: a run of idle bits matching the prediction
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_cnt <= 5'h00;
      locked   <= 1'b0;
    end else if (!descr_on) begin
      lock_cnt <= 5'h00;
      locked   <= 1'b0;
    end else if (rx_rise && !locked) begin
      lock_cnt <= (rx_key == ~rx_nrz) ? lock_cnt + 5'h01 : 5'h00;
      locked   <= lock_cnt == `FEPC_LOCK_RUN;
    end
  end

  // receive framing and decode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_state      <= FEPC_RX_HUNT;
      rx_prev       <= 1'b0;
      rx_win        <= 10'h3FF;
      rx_bit        <= `FEPC_BIT_FIRST;
      mii_rxd       <= 4'h0;
      mii_rx_dv     <= 1'b0;
      mii_rx_er     <= 1'b0;
      mii_rx_strobe <= 1'b0;
    end else begin
      mii_rx_strobe <= 1'b0;
      if (rx_rise) begin
        rx_prev <= rxd_s[1];
        rx_win  <= {rx_win[8:0], rx_plain};
        rx_bit  <= rx_last ? `FEPC_BIT_FIRST : rx_bit + 3'h1;
        if (bypass) begin
          rx_state <= FEPC_RX_HUNT;
          if (rx_last) begin
            {mii_rx_er, mii_rxd} <= rx_grp;
            mii_rx_dv            <= 1'b0;
            mii_rx_strobe        <= 1'b1;
          end
        end else begin
          case (rx_state)
            FEPC_RX_HUNT: begin
              // an untrained descrambler yields garbage that could mimic a start pair
              if ((locked || !descr_on) && {rx_win[8:0], rx_plain} == {`FEPC_CG_J, `FEPC_CG_K}) begin
                rx_state <= FEPC_RX_FRAME;
                rx_bit   <= `FEPC_BIT_FIRST;
              end
            end
            FEPC_RX_FRAME: begin
              if (rx_last) begin
                mii_rx_strobe <= 1'b1;
                mii_rxd       <= dec_res[3:0];
                mii_rx_dv     <= 1'b0;
                mii_rx_er     <= 1'b0;
                if (rx_grp == `FEPC_CG_T) begin
                  rx_state <= FEPC_RX_END;
                end else if (rx_grp == `FEPC_CG_IDLE) begin
                  rx_state  <= FEPC_RX_HUNT;
                  mii_rx_er <= 1'b1;
                end else begin
                  mii_rx_dv <= 1'b1;
                  mii_rx_er <= ~dec_res[4];
                end
              end
            end
            FEPC_RX_END: begin
              if (rx_last) rx_state <= FEPC_RX_HUNT;
            end
            default: rx_state <= FEPC_RX_HUNT;
          endcase
        end
      end
    end
  end

  // carrier sense and collision toward the mac
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mii_crs <= 1'b0;
      mii_col <= 1'b0;
    end else begin
      mii_crs <= tx_busy | rx_busy;
      mii_col <= tx_busy & rx_busy;
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_col_raise: assert property (tx_busy && rx_busy |=> mii_col && mii_crs)
    else $error("collision missed while both directions busy");
  a_crs_idle: assert property (!tx_busy && !rx_busy |=> !mii_crs && !mii_col)
    else $error("carrier sense held with both directions idle");
  a_take_space: assert property (mii_tx_take |=> (!mii_tx_take)[*8])
    else $error("nibbles taken faster than one per group");
  a_start_pair: assert property (mii_tx_take && !bypass && tx_state == FEPC_TX_IDLE && mii_tx_en
                                 |=> tx_shift == `FEPC_CG_J && tx_state == FEPC_TX_K)
    else $error("frame did not open with the start pair");
  a_end_pair: assert property (mii_tx_take && !bypass && tx_state == FEPC_TX_DATA && !mii_tx_en
                               |=> tx_shift == `FEPC_CG_T && tx_state == FEPC_TX_R)
    else $error("frame did not close with the end pair");
  a_err_symbol: assert property (mii_tx_take && !bypass && tx_state == FEPC_TX_DATA
                                 && mii_tx_en && mii_tx_er |=> tx_shift == `FEPC_CG_H)
    else $error("transmit error did not send the error symbol");
  a_data_code: assert property (mii_tx_take && !bypass && tx_state == FEPC_TX_DATA
                                && mii_tx_en && !mii_tx_er |=> tx_shift == enc4b5b($past(mii_txd)))
    else $error("data nibble coded wrongly");
  a_sym_pass: assert property (mii_tx_take && bypass |=> tx_shift == $past({mii_tx_er, mii_txd}))
    else $error("symbol mode altered the symbol");
  a_nrzi_line: assert property (tx_rise && !scr_on |=> (tx_line_data != $past(tx_line_data))
                                == $past(send_bit))
    else $error("line bit not nrzi of the plain group bit");
  a_scr_line: assert property (tx_rise && scr_on |=> (tx_line_data != $past(tx_line_data))
                               == ($past(send_bit) ^ $past(tx_key)))
    else $error("scrambled line bit wrong");
  a_seed_load: assert property (seed_load |=> u_tx_key.state == $past(seed_val))
    else $error("scrambler not seeded from the phy address");
  a_rx_invalid: assert property (rx_rise && !bypass && rx_state == FEPC_RX_FRAME && rx_last
                                 && !dec_res[4] && rx_grp != `FEPC_CG_T && rx_grp != `FEPC_CG_IDLE
                                 |=> mii_rx_strobe && mii_rx_er)
    else $error("invalid group inside a frame not flagged");

  c_tx_frame: cover property (tx_state == FEPC_TX_R ##1 tx_state == FEPC_TX_IDLE);
  c_rx_frame: cover property (rx_state == FEPC_RX_FRAME && mii_rx_strobe && mii_rx_dv);
  c_collide: cover property (mii_col);
  c_locked: cover property (locked && rx_state == FEPC_RX_FRAME);

endmodule : fepc_codec
`default_nettype wire

// ### hw/fepc_regs.svh
// constants of the fast ethernet coding path: register map, code-groups, counts
// assumes inclusion by the package and the design files that need names for numbers
`ifndef FEPC_REGS_SVH
`define FEPC_REGS_SVH

// apb register byte offsets
`define FEPC_ADDR_W      12
`define FEPC_MODE_OFS    12'h054
`define FEPC_STAT_OFS    12'h058

// mode register bit positions and reset value
`define FEPC_MODE_FIBER  0
`define FEPC_MODE_BYPASS 1
`define FEPC_MODE_SCROFF 2
`define FEPC_MODE_RESET  3'h0

// status register bit positions
`define FEPC_STAT_TXBUSY 0
`define FEPC_STAT_RXBUSY 1
`define FEPC_STAT_LOCK   2
`define FEPC_STAT_BYP    3
`define FEPC_STAT_ADDR   4

// line code-groups, first bit on the line is bit 4
`define FEPC_CG_IDLE     5'h1F
`define FEPC_CG_J        5'h18
`define FEPC_CG_K        5'h11
`define FEPC_CG_T        5'h0D
`define FEPC_CG_R        5'h07
`define FEPC_CG_H        5'h04

// bit counter and descrambler lock
`define FEPC_BIT_LAST    3'h4
`define FEPC_BIT_FIRST   3'h0
`define FEPC_LOCK_RUN    5'h1F

// key stream recursion taps, x[n-11] and x[n-9]
`define FEPC_TAP_A       10
`define FEPC_TAP_B       8
`define FEPC_SEED_ZERO   11'h001

`endif

// ### hw/fepc_pkg.sv
// types shared by the coding path files
// assumes fepc_regs.svh sits beside it
`include "fepc_regs.svh"

package fepc_pkg;

  // transmit framing states
  typedef enum logic [1:0] {
    FEPC_TX_IDLE = 2'b00,
    FEPC_TX_K    = 2'b01,
    FEPC_TX_DATA = 2'b10,
    FEPC_TX_R    = 2'b11
  } fepc_tx_state_t;

  // receive framing states
  typedef enum logic [1:0] {
    FEPC_RX_HUNT  = 2'b00,
    FEPC_RX_FRAME = 2'b01,
    FEPC_RX_END   = 2'b10
  } fepc_rx_state_t;

endpackage : fepc_pkg

// ### hw/fepc_lfsr.sv
// eleven stage key stream generator for scrambler and descrambler
// assumes one clock domain; advance marks one line bit time
`timescale 1ns/100ps
`default_nettype none
`include "fepc_regs.svh"

module fepc_lfsr
  import fepc_pkg::*;
#(
  parameter int WIDTH = 11
) (
  // clock and reset
  input  wire  logic             pclk,
  input  wire  logic             presetn,
  // control
  input  wire  logic             load,
  input  wire  logic [WIDTH-1:0] seed,
  input  wire  logic             advance,
  input  wire  logic             train,
  input  wire  logic             train_bit,
  // predicted key bit
  output logic                   pred
);

  logic [WIDTH-1:0] state;

  // the tap positions are fixed, so only eleven stages make sense
  if (WIDTH != 11) begin : g_width_chk
    $error("fepc_lfsr serves eleven stages only");
  end

  // new bit is x[n-11] xor x[n-9]
  assign pred = state[`FEPC_TAP_A] ^ state[`FEPC_TAP_B];

  // shift in the new bit, or the observed one while training
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= `FEPC_SEED_ZERO;
    end else if (load) begin
      state <= seed;
    end else if (advance) begin
      state <= {state[WIDTH-2:0], (train ? train_bit : pred)};
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_lfsr_recur: assert property (advance && !load && !train |=> state[0] == $past(pred)
                                 && state[WIDTH-1:1] == $past(state[WIDTH-2:0]))
    else $error("key stream recursion broken");

endmodule : fepc_lfsr
`default_nettype wire

// ### testbench/fepc_mac_model.sv
// behavioural mac feeding the mii transmit side from a queue of {tx_er, txd}
// assumes the codec's take pulse in the pclk domain
`timescale 1ns/100ps
`default_nettype none

module fepc_mac_model (
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // mii transmit
  input  wire logic       mii_tx_take,
  output logic      [3:0] mii_txd,
  output logic            mii_tx_en,
  output logic            mii_tx_er
);
  logic [4:0] q[$];

  task automatic push(input logic [4:0] v);
    q.push_back(v);
  endtask : push

  // present an entry and hold it until the take pulse; idle data keeps changing
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mii_txd   <= 4'h0;
      mii_tx_en <= 1'b0;
      mii_tx_er <= 1'b0;
    end else if (!mii_tx_en || mii_tx_take) begin
      if (q.size() > 0) begin
        {mii_tx_er, mii_txd} <= q.pop_front();
        mii_tx_en            <= 1'b1;
      end else begin
        mii_tx_en <= 1'b0;
        mii_tx_er <= 1'b0;
        mii_txd   <= ~mii_txd;
      end
    end
  end
endmodule : fepc_mac_model

`default_nettype wire

// ### testbench/fepc_codec_tb.sv
// self-checking bench: apb mode setup, mii frames over a line loopback, line monitor
// assumes the codec, its package and the mac model are compiled first
`timescale 1ns/100ps
`default_nettype none
`include "fepc_regs.svh"

module fepc_codec_tb;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0]  txd, rxd;
  logic        pready, pslverr, take, tx_en, tx_er, rx_dv, rx_er, rx_stb, crs, col, er;
  logic        strap = 1'b0, lclk = 1'b0, ldata, last = 1'b0, jk = 1'b0, cols = 1'b0, crss = 1'b0;
  logic [9:0]  sh = 10'h000;
  logic [4:0]  rxq[$];
  int          zeros = 0, ends = 0, end_er = 0, error_cnt = 0, check_count = 0, cyc = 0;

  always #20 pclk = ~pclk;
  initial #7 forever #160 lclk = ~lclk;

  fepc_codec dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mii_txd(txd), .mii_tx_en(tx_en), .mii_tx_er(tx_er), .mii_tx_take(take), .mii_rxd(rxd),
    .mii_rx_dv(rx_dv), .mii_rx_er(rx_er), .mii_rx_strobe(rx_stb), .mii_crs(crs), .mii_col(col),
    .phy_addr(5'h13), .coding_bypass_strap(strap), .tx_line_clk(lclk), .tx_line_data(ldata),
    .rx_line_clk(~lclk), .rx_line_data(ldata));

  fepc_mac_model mac_u (.pclk(pclk), .presetn(presetn), .mii_tx_take(take), .mii_txd(txd),
    .mii_tx_en(tx_en), .mii_tx_er(tx_er));

  // received nibbles, frame ends, carrier flags and the run ceiling
  always @(posedge pclk) begin
    if (rx_stb === 1'b1 && rx_dv === 1'b1) rxq.push_back({rx_er, rxd});
    if (rx_stb === 1'b1 && rx_dv === 1'b0) begin
      ends++;
      end_er += rx_er;
    end
    if (col === 1'b1) cols = 1'b1;
    if (crs === 1'b1) crss = 1'b1;
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      end_sim();
    end
  end

  // nrzi to nrz on the line, looking for a start pair and for zero bits
  always @(negedge lclk) begin
    sh = {sh[8:0], ldata ^ last};
    last = ldata;
    if (sh == 10'h311) jk = 1'b1;
    if (sh[0] === 1'b0) zeros++;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic frame(input logic [31:0] m);
    apb(1'b1, `FEPC_MODE_OFS, m);
    // let the group in flight under the old mode leave the line
    repeat (80) @(posedge pclk);
    zeros = 0;
    repeat (800) @(posedge pclk);
    chk(zeros > 0, m == 0);
    rxq.delete();
    {jk, cols, crss, ends, end_er} = '0;
    mac_u.push(5'h05);
    mac_u.push(5'h05);
    for (int i = 0; i < 16; i++) mac_u.push(5'(i));
    mac_u.push(5'h1A);
    for (int i = 0; i < 3000 && ends == 0; i++) @(posedge pclk);
    chk(rxq.size(), 17);
    for (int i = 0; i < 16 && i < rxq.size(); i++) chk(rxq[i], 5'(i));
    if (rxq.size() == 17) chk(rxq[16][4], 1'b1);
    chk(end_er, 0);
    chk({cols, crss}, 2'b11);
    if (m != 0) chk(jk, 1'b1);
  endtask : frame

  task automatic end_sim();
    if (error_cnt == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_sim

  // registers, three coding modes, symbol mode, strap
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `FEPC_MODE_OFS, 32'h0);
    chk(rd, `FEPC_MODE_RESET);
    apb(1'b1, `FEPC_MODE_OFS, 32'hFFFFFFFF);
    apb(1'b0, `FEPC_MODE_OFS, 32'h0);
    chk(rd, 32'h7);
    apb(1'b1, 12'h100, 32'h1);
    chk(er, 1'b1);
    apb(1'b0, 12'h100, 32'h0);
    chk(rd, 32'h0);
    chk(er, 1'b1);
    frame(32'h4);
    frame(32'h1);
    frame(32'h0);
    apb(1'b0, `FEPC_STAT_OFS, 32'h0);
    chk(rd[`FEPC_STAT_LOCK], 1'b1);
    apb(1'b1, `FEPC_MODE_OFS, 32'h2);
    jk = 1'b0;
    rxq.delete();
    mac_u.push(`FEPC_CG_J);
    mac_u.push(`FEPC_CG_K);
    repeat (400) @(posedge pclk);
    chk({jk, rxq.size() == 0}, 2'b11);
    apb(1'b1, `FEPC_MODE_OFS, 32'h0);
    strap <= 1'b1;
    repeat (4) @(posedge pclk);
    apb(1'b0, `FEPC_STAT_OFS, 32'h0);
    chk(rd[8:3], {5'h13, 1'b1});
    end_sim();
  end
endmodule : fepc_codec_tb

`default_nettype wire
